// file: spmsd_consts.svh
// Constants of the servo panel mode and status display block
`ifndef SPMSD_CONSTS_SVH
`define SPMSD_CONSTS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPMSD_OFF_CFG 8'h00
`define SPMSD_OFF_SPD_WIN 8'h04
`define SPMSD_OFF_POS_WIN 8'h08
`define SPMSD_OFF_ROT_THR 8'h0C
`define SPMSD_OFF_TRQ_THR 8'h10
`define SPMSD_OFF_LIMITS 8'h14
`define SPMSD_OFF_STATUS 8'h18
`define SPMSD_OFF_EDIT 8'h1C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPMSD_RST_CFG 2'h0
`define SPMSD_RST_SPD_WIN 16'h000A
`define SPMSD_RST_POS_WIN 16'h000A
`define SPMSD_RST_ROT_THR 16'h0014
`define SPMSD_RST_TRQ_THR 16'h000A
`define SPMSD_RST_EDIT_MIN 16'h0000
`define SPMSD_RST_EDIT_MAX 16'hFFFF
`define SPMSD_RST_EDIT 16'h0000
// ----------------------------------------
// Status codes and bit positions
// ----------------------------------------
`define SPMSD_CODE_SERVO_OFF 8'h00
`define SPMSD_CODE_RUN 8'h01
`define SPMSD_CODE_FWD_PROH 8'h02
`define SPMSD_CODE_REV_PROH 8'h03
`define SPMSD_BIT_MATCH 0
`define SPMSD_BIT_BASE 1
`define SPMSD_BIT_CPWR 2
`define SPMSD_BIT_SREF 3
`define SPMSD_BIT_TREF 4
`define SPMSD_BIT_PRDY 5
`define SPMSD_BIT_ROT 6
`define SPMSD_KEY_MODE 0
`define SPMSD_KEY_ENTER 1
`define SPMSD_KEY_INC 2
`define SPMSD_KEY_DEC 3
`define SPMSD_ONE16 16'h0001
`endif

// file: spmsd_key_edge.sv
// Press detector for the four panel keys
`timescale 1ns/1ps
`default_nettype none
module spmsd_key_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] keys,
  output logic [3:0] press
);
  logic [3:0] keys_q;

  // One pulse per press; holding a key gives no repeat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_q <= 4'h0;
      press <= 4'h0;
    end else begin
      keys_q <= keys;
      press <= keys & ~keys_q;
    end
  end
endmodule
`default_nettype wire

// file: spmsd_operator.sv
// Operator model pressing the front panel keys one at a time
`timescale 1ns/1ps
`default_nettype none
module spmsd_operator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] which,
  output logic [3:0] keys,
  output logic busy
);
  logic [2:0] cnt;
  logic [1:0] sel;
  // ----------------------------------------
  // Press sequencer
  // ----------------------------------------
  // Key held three cycles, then three cycles low so the next press is a fresh edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      sel <= 2'h0;
    end else if (cnt != 3'h0) begin
      cnt <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
    end else if (go) begin
      cnt <= 3'h1;
      sel <= which;
    end
  end
  // One key at a time; a human never chords inc and dec here
  assign keys = (cnt >= 3'h1 && cnt <= 3'h3) ? (4'h1 << sel) : 4'h0;
  assign busy = (cnt != 3'h0);
endmodule
`default_nettype wire

// file: spmsd_pkg.sv
// Types shared by the servo panel block
package spmsd_pkg;
  typedef enum logic [1:0] {MODE_STATUS, MODE_PARAM, MODE_MONITOR, MODE_UTILITY} spmsd_mode_t;
  typedef enum logic [1:0] {CT_SPEED, CT_TORQUE, CT_POSITION, CT_SPARE} spmsd_ctrl_t;
endpackage

// file: spmsd_status_bits.sv
// Status bit display, meaning set by control type
`timescale 1ns/1ps
`default_nettype none
`include "spmsd_consts.svh"
module spmsd_status_bits (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] ctrl_type,
  input wire logic [15:0] speed_match_window,
  input wire logic [15:0] position_done_window,
  input wire logic [15:0] rotation_threshold,
  input wire logic [15:0] torque_threshold,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] ref_speed,
  input wire logic signed [15:0] torque_ref,
  input wire logic signed [15:0] position_error,
  input wire logic ref_pulse_active,
  input wire logic err_clear_active,
  input wire logic base_block,
  input wire logic control_power,
  input wire logic main_power_ok,
  output logic [6:0] bits
);
  import spmsd_pkg::*;

  // Magnitude of a signed value; widened so the most negative fits
  function automatic logic [16:0] mag(input logic signed [16:0] v);
    mag = v[16] ? 17'(-v) : 17'(v);
  endfunction

  logic [16:0] speed_err;
  logic is_pos;
  logic [6:0] next_bits;
  assign speed_err = mag(17'(motor_speed) - 17'(ref_speed));
  assign is_pos = (ctrl_type == CT_POSITION);

  // Bit meanings swap between speed/torque and position control
  always_comb begin
    next_bits = 7'h00;
    if (is_pos) begin
      next_bits[`SPMSD_BIT_MATCH] = mag(17'(position_error)) < {1'b0, position_done_window};
      next_bits[`SPMSD_BIT_SREF] = ref_pulse_active;
      next_bits[`SPMSD_BIT_TREF] = err_clear_active;
    end else begin
      next_bits[`SPMSD_BIT_MATCH] = (ctrl_type == CT_TORQUE) ||
        (speed_err <= {1'b0, speed_match_window});
      next_bits[`SPMSD_BIT_SREF] = mag(17'(ref_speed)) > {1'b0, rotation_threshold};
      next_bits[`SPMSD_BIT_TREF] = mag(17'(torque_ref)) > {1'b0, torque_threshold};
    end
    next_bits[`SPMSD_BIT_BASE] = base_block;
    next_bits[`SPMSD_BIT_CPWR] = control_power;
    next_bits[`SPMSD_BIT_PRDY] = main_power_ok;
    next_bits[`SPMSD_BIT_ROT] = mag(17'(motor_speed)) > {1'b0, rotation_threshold};
  end

  // Registered so the display never shows a combinational glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits <= 7'h00;
    end else begin
      bits <= next_bits;
    end
  end
endmodule
`default_nettype wire

// file: spmsd_tb_top.sv
// Self-checking bench of the servo panel block
`timescale 1ns/1ps
`default_nettype none
`include "spmsd_consts.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module spmsd_tb_top;
  import spmsd_pkg::*;
  typedef struct {
    logic [1:0] ct;
    logic [15:0] ms, rs, tq, pe;
    logic [6:0] flg;
    logic [6:0] bits;
    logic [7:0] code;
  } spmsd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] which;
  logic [3:0] keys;
  logic alarm_clear_input, alarm_set, fot, rot, rp, ec, bb, cp, mp, err;
  logic [7:0] alarm_number, status_code;
  logic signed [15:0] ms, rs, tq, pe;
  spmsd_mode_t panel_mode;
  logic edit_active, alarm_active, code_is_alarm;
  logic [15:0] edit_value, edit_work;
  logic [6:0] status_bits;
  int num_errors, num_checks, cycles;
  // Flags are {ref pulse, err clear, base block, ctrl pwr, main pwr, fwd ot, rev ot}; ffxx are negatives
  spmsd_row_t rows [7] = '{
    '{2'h0, 16'h0064, 16'h005f, 16'h000b, 16'h0000, 7'h1f, 7'h7f, 8'h00},
    '{2'h0, 16'h0014, 16'h000a, 16'h000a, 16'h0000, 7'h0b, 7'h05, 8'h01},
    '{2'h0, 16'h0015, 16'hffe2, 16'h0000, 16'h0000, 7'h05, 7'h68, 8'h02},
    '{2'h1, 16'h01f4, 16'h0000, 16'h0032, 16'h0000, 7'h0e, 7'h75, 8'h03},
    '{2'h2, 16'h0000, 16'h0064, 16'h0064, 16'h0009, 7'h4c, 7'h2d, 8'h02},
    '{2'h2, 16'hffe7, 16'h0000, 16'h0000, 16'h000a, 7'h3b, 7'h56, 8'h00},
    '{2'h2, 16'h0000, 16'h0064, 16'h0064, 16'hfff7, 7'h0f, 7'h25, 8'h01}};
  logic [7:0] radr [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rexp [5] = '{32'h0000_000a, 32'h0000_000a, 32'h0000_0014, 32'h0000_000a, 32'hffff_0000};
  spmsd_top spmsd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_key(keys[`SPMSD_KEY_MODE]), .enter_key(keys[`SPMSD_KEY_ENTER]),
    .increment_key(keys[`SPMSD_KEY_INC]), .decrement_key(keys[`SPMSD_KEY_DEC]),
    .alarm_clear_input(alarm_clear_input), .alarm_set(alarm_set), .alarm_number(alarm_number),
    .forward_overtravel_input(fot), .reverse_overtravel_input(rot), .motor_speed(ms), .ref_speed(rs),
    .torque_ref(tq), .position_error(pe), .ref_pulse_active(rp), .err_clear_active(ec), .base_block(bb),
    .control_power(cp), .main_power_ok(mp), .panel_mode(panel_mode), .edit_active(edit_active),
    .edit_value(edit_value), .edit_work(edit_work), .alarm_active(alarm_active),
    .status_bits(status_bits), .status_code(status_code), .code_is_alarm(code_is_alarm));
  spmsd_operator spmsd_operator_i (.pclk(pclk), .presetn(presetn), .go(go), .which(which), .keys(keys),
    .busy(busy));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Whole run is a few hundred cycles; the ceiling leaves ample slack
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // APB transfer; waits on pready, never assumes the wait-state count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Ask the operator for one press and wait until the keys are quiet again
  task automatic press(input int k);
    int n;
    @(posedge pclk);
    go <= 1'b1;
    which <= 2'(k);
    @(posedge pclk);
    go <= 1'b0;
    // Busy rises on the edge that takes go, after this task resumes there, so let one more edge pass first
    @(posedge pclk);
    for (n = 0; n < 20 && busy === 1'b1; n++) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, go, alarm_set, alarm_clear_input, rp, ec, bb, cp, mp} = '0;
    {fot, rot} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    which = 2'h0;
    alarm_number = 8'h00;
    {ms, rs, tq, pe} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("mode after reset", MODE_STATUS, panel_mode)
    `CHK("alarm after reset", 1'b0, alarm_active)
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, radr[i], 32'h0000_0000);
      `CHK("reset value", rexp[i], rd)
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, err)
    $display("test reset done");
    // Status bits and codes, one row per operating point
    foreach (rows[i]) begin
      apb(1'b1, `SPMSD_OFF_CFG, {30'h0, rows[i].ct});
      @(posedge pclk);
      {ms, rs, tq, pe} <= {rows[i].ms, rows[i].rs, rows[i].tq, rows[i].pe};
      {rp, ec, bb, cp, mp, fot, rot} <= rows[i].flg;
      repeat (4) @(posedge pclk);
      `CHK("status bits", rows[i].bits, status_bits)
      `CHK("status code", rows[i].code, status_code)
    end
    $display("test status table done");
    // Alarm outranks overtravel, then clears by enter and by the input
    @(posedge pclk);
    fot <= 1'b0;
    alarm_set <= 1'b1;
    alarm_number <= 8'h5a;
    @(posedge pclk);
    alarm_set <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("alarm code", 8'h5a, status_code)
    `CHK("alarm flag", 1'b1, code_is_alarm)
    press(`SPMSD_KEY_ENTER);
    `CHK("enter clears", 1'b0, alarm_active)
    `CHK("code after clear", `SPMSD_CODE_FWD_PROH, status_code)
    @(posedge pclk);
    alarm_set <= 1'b1;
    @(posedge pclk);
    alarm_set <= 1'b0;
    alarm_clear_input <= 1'b1;
    @(posedge pclk);
    alarm_clear_input <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("input clears", 1'b0, alarm_active)
    $display("test alarm done");
    // Four presses walk the ring back to status display
    for (int i = 1; i <= 4; i++) begin
      press(`SPMSD_KEY_MODE);
      `CHK("mode step", spmsd_mode_t'(i % 4), panel_mode)
    end
    press(`SPMSD_KEY_MODE);
    apb(1'b0, `SPMSD_OFF_STATUS, 32'h0000_0000);
    `CHK("status reg mode", 2'h1, rd[1:0])
    $display("test mode ring done");
    // Edit: floor, raise, lower, store with mode key
    press(`SPMSD_KEY_ENTER);
    `CHK("edit open", 1'b1, edit_active)
    press(`SPMSD_KEY_DEC);
    `CHK("floor", 16'h0000, edit_work)
    press(`SPMSD_KEY_INC);
    press(`SPMSD_KEY_INC);
    press(`SPMSD_KEY_DEC);
    `CHK("inc dec", 16'h0001, edit_work)
    press(`SPMSD_KEY_MODE);
    `CHK("stored", 16'h0001, edit_value)
    `CHK("edit left", 1'b0, edit_active)
    `CHK("mode kept", MODE_PARAM, panel_mode)
    // Ceiling at a small maximum
    apb(1'b1, `SPMSD_OFF_LIMITS, 32'h0002_0000);
    press(`SPMSD_KEY_ENTER);
    press(`SPMSD_KEY_INC);
    press(`SPMSD_KEY_INC);
    `CHK("ceiling", 16'h0002, edit_work)
    $display("test edit done");
    end_of_test();
  end
endmodule
`default_nettype wire

// file: spmsd_top.sv
// Front panel mode, edit, alarm and status display with APB registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spmsd_consts.svh"
module spmsd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mode_key,
  input wire logic enter_key,
  input wire logic increment_key,
  input wire logic decrement_key,
  input wire logic alarm_clear_input,
  input wire logic alarm_set,
  input wire logic [7:0] alarm_number,
  input wire logic forward_overtravel_input,
  input wire logic reverse_overtravel_input,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [15:0] ref_speed,
  input wire logic signed [15:0] torque_ref,
  input wire logic signed [15:0] position_error,
  input wire logic ref_pulse_active,
  input wire logic err_clear_active,
  input wire logic base_block,
  input wire logic control_power,
  input wire logic main_power_ok,
  output spmsd_pkg::spmsd_mode_t panel_mode,
  output logic edit_active,
  output logic [15:0] edit_value,
  output logic [15:0] edit_work,
  output logic alarm_active,
  output logic [6:0] status_bits,
  output logic [7:0] status_code,
  output logic code_is_alarm
);
  import spmsd_pkg::*;

  // ----------------------------------------
  // Registers and key presses
  // ----------------------------------------
  logic [1:0] ctrl_type;
  logic [15:0] speed_match_window;
  logic [15:0] position_done_window;
  logic [15:0] rotation_threshold;
  logic [15:0] torque_threshold;
  logic [15:0] edit_min;
  logic [15:0] edit_max;
  logic [7:0] alarm_held;
  logic [3:0] press;
  logic press_mode, press_enter, press_inc, press_dec;
  logic bus_wr, bus_rd, clear_req;
  logic [31:0] next_prdata;
  logic next_slverr;

  spmsd_key_edge u_keys (
    .pclk(pclk),
    .presetn(presetn),
    .keys({decrement_key, increment_key, enter_key, mode_key}),
    .press(press)
  );

  spmsd_status_bits u_bits (
    .pclk(pclk),
    .presetn(presetn),
    .ctrl_type(ctrl_type),
    .speed_match_window(speed_match_window),
    .position_done_window(position_done_window),
    .rotation_threshold(rotation_threshold),
    .torque_threshold(torque_threshold),
    .motor_speed(motor_speed),
    .ref_speed(ref_speed),
    .torque_ref(torque_ref),
    .position_error(position_error),
    .ref_pulse_active(ref_pulse_active),
    .err_clear_active(err_clear_active),
    .base_block(base_block),
    .control_power(control_power),
    .main_power_ok(main_power_ok),
    .bits(status_bits)
  );

  assign press_mode = press[`SPMSD_KEY_MODE];
  assign press_enter = press[`SPMSD_KEY_ENTER];
  assign press_inc = press[`SPMSD_KEY_INC];
  assign press_dec = press[`SPMSD_KEY_DEC];

  // Next basic mode; utility wraps back to status display
  function automatic spmsd_mode_t next_mode(input spmsd_mode_t m);
    unique case (m)
      MODE_STATUS: next_mode = MODE_PARAM;
      MODE_PARAM: next_mode = MODE_MONITOR;
      MODE_MONITOR: next_mode = MODE_UTILITY;
      MODE_UTILITY: next_mode = MODE_STATUS;
    endcase
  endfunction

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  // Write lands on the edge where pready is high; read data is captured on the edge that raises pready
  assign bus_wr = psel && penable && pready && pwrite;
  assign bus_rd = psel && penable && !pready && !pwrite;

  // Read mux; unmapped offsets answer with an error and zero data
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `SPMSD_OFF_CFG: next_prdata = {30'h0000_0000, ctrl_type};
      `SPMSD_OFF_SPD_WIN: next_prdata = {16'h0000, speed_match_window};
      `SPMSD_OFF_POS_WIN: next_prdata = {16'h0000, position_done_window};
      `SPMSD_OFF_ROT_THR: next_prdata = {16'h0000, rotation_threshold};
      `SPMSD_OFF_TRQ_THR: next_prdata = {16'h0000, torque_threshold};
      `SPMSD_OFF_LIMITS: next_prdata = {edit_max, edit_min};
      `SPMSD_OFF_STATUS: next_prdata = {8'h00, status_code, 4'h0, code_is_alarm, status_bits,
                                        alarm_active, edit_active, panel_mode};
      `SPMSD_OFF_EDIT: next_prdata = {edit_work, edit_value};
      default: next_slverr = 1'b1;
    endcase
  end

  // Handshake: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_slverr;
      if (bus_rd) begin
        prdata <= next_prdata;
      end
    end
  end

  // Configuration registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_type <= `SPMSD_RST_CFG;
      speed_match_window <= `SPMSD_RST_SPD_WIN;
      position_done_window <= `SPMSD_RST_POS_WIN;
      rotation_threshold <= `SPMSD_RST_ROT_THR;
      torque_threshold <= `SPMSD_RST_TRQ_THR;
      edit_min <= `SPMSD_RST_EDIT_MIN;
      edit_max <= `SPMSD_RST_EDIT_MAX;
    end else if (bus_wr) begin
      case (paddr)
        `SPMSD_OFF_CFG: ctrl_type <= pwdata[1:0];
        `SPMSD_OFF_SPD_WIN: speed_match_window <= pwdata[15:0];
        `SPMSD_OFF_POS_WIN: position_done_window <= pwdata[15:0];
        `SPMSD_OFF_ROT_THR: rotation_threshold <= pwdata[15:0];
        `SPMSD_OFF_TRQ_THR: torque_threshold <= pwdata[15:0];
        `SPMSD_OFF_LIMITS: begin
          edit_min <= pwdata[15:0];
          edit_max <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Mode selection and parameter edit
  // ----------------------------------------
  // Mode key inside an edit saves and exits instead of advancing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_mode <= MODE_STATUS;
    end else if (press_mode && !edit_active) begin
      panel_mode <= next_mode(panel_mode);
    end
  end

  // Enter opens an edit in parameter mode; enter or mode closes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edit_active <= 1'b0;
      edit_value <= `SPMSD_RST_EDIT;
      edit_work <= `SPMSD_RST_EDIT;
    end else if (edit_active) begin
      if (press_mode || press_enter) begin
        edit_active <= 1'b0;
        edit_value <= edit_work;
      end else if (press_inc && !press_dec && edit_work < edit_max) begin
        edit_work <= edit_work + `SPMSD_ONE16;
      end else if (press_dec && !press_inc && edit_work > edit_min) begin
        edit_work <= edit_work - `SPMSD_ONE16;
      end
    end else if (press_enter && panel_mode == MODE_PARAM) begin
      edit_active <= 1'b1;
      edit_work <= edit_value;
    end
  end

  // ----------------------------------------
  // Alarm latch and status code
  // ----------------------------------------
  // A new alarm in the clearing cycle wins, so no alarm is lost
  assign clear_req = alarm_clear_input || (press_enter && panel_mode == MODE_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_active <= 1'b0;
      alarm_held <= 8'h00;
    end else if (alarm_set) begin
      alarm_active <= 1'b1;
      alarm_held <= alarm_number;
    end else if (clear_req) begin
      alarm_active <= 1'b0;
    end
  end

  // Priority: alarm, then overtravel, then run or servo off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_code <= `SPMSD_CODE_SERVO_OFF;
      code_is_alarm <= 1'b0;
    end else begin
      code_is_alarm <= alarm_active;
      if (alarm_active) begin
        status_code <= alarm_held;
      end else if (!forward_overtravel_input) begin
        status_code <= `SPMSD_CODE_FWD_PROH;
      end else if (!reverse_overtravel_input) begin
        status_code <= `SPMSD_CODE_REV_PROH;
      end else if (base_block) begin
        status_code <= `SPMSD_CODE_SERVO_OFF;
      end else begin
        status_code <= `SPMSD_CODE_RUN;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Helper: set once any key press has been seen since reset
  logic any_press;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_press <= 1'b0;
    end else if (press != 4'h0) begin
      any_press <= 1'b1;
    end
  end

  AST_MODE_STEP: assert property (press_mode && !edit_active && panel_mode == MODE_MONITOR
    |=> panel_mode == MODE_UTILITY) else $error("mode key did not advance");
  AST_MODE_WRAP: assert property (press_mode && !edit_active && panel_mode == MODE_UTILITY
    |=> panel_mode == MODE_STATUS) else $error("mode did not wrap to status");
  AST_POWER_ON_MODE: assert property (!any_press |-> panel_mode == MODE_STATUS)
    else $error("not in status mode before first key");
  AST_ENTER_CLEAR: assert property (press_enter && panel_mode == MODE_STATUS && !alarm_set
    |=> !alarm_active) else $error("enter did not clear alarm");
  AST_EXT_CLEAR: assert property (alarm_clear_input && !alarm_set |=> !alarm_active)
    else $error("external clear ignored");
  AST_SET_WINS: assert property (alarm_set |=> alarm_active ##1 code_is_alarm)
    else $error("alarm lost or not shown");
  AST_EDIT_STORE: assert property (edit_active && press_mode
    |=> !edit_active && edit_value == $past(edit_work) && $stable(panel_mode))
    else $error("mode key did not store edit");
  AST_INC_STEP: assert property (edit_active && press_inc && !press_dec && !press_mode && !press_enter
    && edit_work < edit_max |=> edit_work == $past(edit_work) + `SPMSD_ONE16)
    else $error("increment failed");
  AST_SATURATE: assert property (edit_active && press_dec && edit_work <= edit_min
    |=> edit_work == $past(edit_work)) else $error("decrement passed minimum");
  AST_TORQUE_MATCH: assert property (ctrl_type == CT_TORQUE ##1 ctrl_type == CT_TORQUE
    |-> status_bits[`SPMSD_BIT_MATCH]) else $error("torque match bit not forced");
  AST_BASE_BIT: assert property (base_block |=> status_bits[`SPMSD_BIT_BASE])
    else $error("base block bit not set");
  AST_FWD_PROH: assert property (!alarm_active && !forward_overtravel_input
    |=> status_code == `SPMSD_CODE_FWD_PROH && !code_is_alarm) else $error("forward prohibit code missing");
  AST_RUN_CODE: assert property (!alarm_active && forward_overtravel_input && reverse_overtravel_input
    && !base_block |=> status_code == `SPMSD_CODE_RUN) else $error("run code missing");

  COV_WRAP: cover property (press_mode && !edit_active && panel_mode == MODE_UTILITY);
  COV_ENTER_CLEAR: cover property (alarm_active && press_enter && panel_mode == MODE_STATUS);
  COV_EDIT_SAVE: cover property (edit_active && press_inc ##[1:20] edit_active && press_mode);
  COV_SAT_MAX: cover property (edit_active && press_inc && edit_work == edit_max);
endmodule
`default_nettype wire
